// file: hdl/eeprom_host.sv
// Host controller that drives a byte-wide parallel EEPROM through its pins.
// Assumes pin inputs are synchronous to clk_sys and that an outside wire model
// resolves the data lanes from byte_lanes_oe; the elevated levels are qualifiers.
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_host_params.svh"

module eeprom_host #(
  parameter int unsigned WRITE_CYCLE_NS = `T_WRITE_CYCLE_NS,
  parameter int unsigned LOCKOUT_NS = `T_LOCKOUT_NS,
  parameter int unsigned ERASE_PULSE_NS = `T_ERASE_PULSE_NS,
  parameter bit USE_READY_LINE = 1'b1
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic req_valid,
  input wire eeprom_host_pkg::req_type req,
  output logic req_ready,
  output logic rsp_valid,
  output eeprom_host_pkg::rsp_type rsp,
  output eeprom_host_pkg::pins_type pins,
  input wire logic [`DATA_W-1:0] byte_lanes_in,
  input wire logic write_done_flag
);

  localparam int unsigned WC_CYC = eeprom_host_pkg::cyc_dn(WRITE_CYCLE_NS);
  localparam int unsigned LOCK_CYC = eeprom_host_pkg::cyc_up(LOCKOUT_NS);
  localparam int unsigned ERASE_CYC = eeprom_host_pkg::cyc_up(ERASE_PULSE_NS);
  localparam int unsigned AS_CYC = eeprom_host_pkg::cyc_up(`T_ADDR_SETUP_NS);
  localparam int unsigned WP_CYC = eeprom_host_pkg::cyc_up(`T_WRITE_PULSE_NS);
  localparam int unsigned DH_CYC = eeprom_host_pkg::cyc_up(`T_DATA_HOLD_NS);
  localparam int unsigned ACC_CYC = eeprom_host_pkg::cyc_up(`T_READ_ACCESS_NS);
  localparam int unsigned DB_CYC = eeprom_host_pkg::cyc_up(`T_TO_BUSY_NS);
  localparam int unsigned GAP_CYC = eeprom_host_pkg::cyc_up(`T_POLL_GAP_NS);

  typedef struct packed {
    eeprom_host_pkg::state_type st;
    eeprom_host_pkg::cmd_type cmd;
    logic [`DATA_W-1:0] wdata;
    logic [`CNT_W-1:0] wc_cnt;
    logic req_ready;
    logic rsp_valid;
    eeprom_host_pkg::rsp_type rsp;
    eeprom_host_pkg::pins_type pins;
  } host_state_type;

  localparam eeprom_host_pkg::pins_type PINS_IDLE = '{
    word_address: '0,
    byte_lanes_out: '0,
    byte_lanes_oe: 1'b0,
    chip_select_n: 1'b1,
    output_gate_n: 1'b1,
    write_strobe_n: 1'b1,
    output_gate_elevated: 1'b0,
    address_line_nine_elevated: 1'b0
  };

  // Power-on lockout is counted out before the first request is taken
  localparam host_state_type RST_Q = '{
    st: eeprom_host_pkg::ST_LOCKOUT,
    cmd: eeprom_host_pkg::CMD_READ,
    wdata: '0,
    wc_cnt: eeprom_host_pkg::ld(LOCK_CYC),
    req_ready: 1'b0,
    rsp_valid: 1'b0,
    rsp: '0,
    pins: PINS_IDLE
  };

  host_state_type q;
  host_state_type d;
  logic t_load;
  logic [`CNT_W-1:0] t_value;
  logic t_expired;
  logic is_id;

  interval_timer u_timer (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .clk_en(clk_en),
    .load(t_load),
    .load_value(t_value),
    .expired(t_expired)
  );

  assign is_id = (req.cmd == eeprom_host_pkg::CMD_ID_READ) ||
                 (req.cmd == eeprom_host_pkg::CMD_ID_WRITE);

  always_comb begin
    d = q;
    t_load = 1'b0;
    t_value = '0;
    d.rsp_valid = 1'b0;
    if (q.wc_cnt != '0) begin
      d.wc_cnt = q.wc_cnt - `CNT_W'(1);
    end
    case (q.st)
      eeprom_host_pkg::ST_LOCKOUT: begin
        if (q.wc_cnt == '0) begin // see [R15]
          d.st = eeprom_host_pkg::ST_IDLE;
          d.req_ready = 1'b1;
        end
      end
      eeprom_host_pkg::ST_IDLE: begin
        if (req_valid) begin
          d.req_ready = 1'b0;
          d.cmd = req.cmd;
          d.wdata = req.data;
          d.rsp = '0;
          // Identification bytes sit in the top 32 locations
          d.pins.word_address = is_id ? {`ID_HIGH_BITS, req.addr[`ID_OFS_W-1:0]} :
                                req.addr; // see [R18] see [R1]
          d.pins.address_line_nine_elevated = is_id; // see [R19]
          d.pins.chip_select_n = 1'b0;
          t_load = 1'b1;
          case (req.cmd)
            eeprom_host_pkg::CMD_READ, eeprom_host_pkg::CMD_ID_READ: begin
              d.pins.output_gate_n = 1'b0; // see [R2]
              t_value = eeprom_host_pkg::ld(ACC_CYC);
              d.st = eeprom_host_pkg::ST_R_ACCESS;
            end
            eeprom_host_pkg::CMD_WRITE, eeprom_host_pkg::CMD_ID_WRITE: begin
              d.pins.byte_lanes_out = req.data;
              d.pins.byte_lanes_oe = 1'b1;
              t_value = eeprom_host_pkg::ld(AS_CYC);
              d.st = eeprom_host_pkg::ST_W_SETUP;
            end
            eeprom_host_pkg::CMD_ERASE: begin
              d.pins.output_gate_elevated = 1'b1; // see [R17] see [R19]
              t_value = eeprom_host_pkg::ld(AS_CYC);
              d.st = eeprom_host_pkg::ST_E_SETUP;
            end
            default: begin
              d.pins = PINS_IDLE;
              d.rsp.error = 1'b1;
              d.st = eeprom_host_pkg::ST_FINISH;
            end
          endcase
        end
      end
      eeprom_host_pkg::ST_W_SETUP: begin
        if (t_expired) begin
          // Gate stays high and select low so the strobe pulse starts a write
          d.pins.write_strobe_n = 1'b0; // see [R4] see [R16]
          t_load = 1'b1;
          t_value = eeprom_host_pkg::ld(WP_CYC);
          d.st = eeprom_host_pkg::ST_W_PULSE;
        end
      end
      eeprom_host_pkg::ST_W_PULSE: begin
        if (t_expired) begin
          d.pins.write_strobe_n = 1'b1; // see [R5]
          t_load = 1'b1;
          t_value = eeprom_host_pkg::ld(DH_CYC);
          d.st = eeprom_host_pkg::ST_W_HOLD;
        end
      end
      eeprom_host_pkg::ST_W_HOLD: begin
        if (t_expired) begin
          d.pins.byte_lanes_oe = 1'b0;
          d.pins.chip_select_n = 1'b1;
          d.wc_cnt = eeprom_host_pkg::ld(WC_CYC); // see [R7] see [R21]
          t_load = 1'b1;
          t_value = eeprom_host_pkg::ld(DB_CYC);
          d.st = eeprom_host_pkg::ST_W_SETTLE;
        end
      end
      eeprom_host_pkg::ST_W_SETTLE: begin
        // Busy takes time to appear, so the flag is not looked at before then
        if (t_expired) begin
          if (USE_READY_LINE) begin
            d.st = eeprom_host_pkg::ST_W_WAIT;
          end else begin
            d.pins.chip_select_n = 1'b0; // see [R10] see [R8]
            d.pins.output_gate_n = 1'b0;
            t_load = 1'b1;
            t_value = eeprom_host_pkg::ld(ACC_CYC);
            d.st = eeprom_host_pkg::ST_P_ACCESS;
          end
        end
      end
      eeprom_host_pkg::ST_W_WAIT: begin
        if (write_done_flag) begin // see [R9] see [R13]
          d.st = eeprom_host_pkg::ST_FINISH;
        end else if (q.wc_cnt == '0) begin
          d.rsp.error = 1'b1;
          d.st = eeprom_host_pkg::ST_FINISH;
        end
      end
      eeprom_host_pkg::ST_P_ACCESS: begin
        if (t_expired) begin
          d.pins.chip_select_n = 1'b1; // see [R3]
          d.pins.output_gate_n = 1'b1;
          // Inverted bit 7 means still busy; a match means true data is back
          if (byte_lanes_in[`POLL_BIT] == q.wdata[`POLL_BIT]) begin // see [R11] see [R12]
            d.rsp.data = byte_lanes_in;
            d.st = eeprom_host_pkg::ST_FINISH;
          end else if (q.wc_cnt == '0) begin
            d.rsp.error = 1'b1;
            d.st = eeprom_host_pkg::ST_FINISH;
          end else begin
            t_load = 1'b1;
            t_value = eeprom_host_pkg::ld(GAP_CYC);
            d.st = eeprom_host_pkg::ST_P_GAP;
          end
        end
      end
      eeprom_host_pkg::ST_P_GAP: begin
        if (t_expired) begin
          d.pins.chip_select_n = 1'b0; // see [R13]
          d.pins.output_gate_n = 1'b0;
          t_load = 1'b1;
          t_value = eeprom_host_pkg::ld(ACC_CYC);
          d.st = eeprom_host_pkg::ST_P_ACCESS;
        end
      end
      eeprom_host_pkg::ST_R_ACCESS: begin
        if (t_expired) begin
          d.rsp.data = byte_lanes_in; // see [R2] see [R20]
          d.pins.chip_select_n = 1'b1;
          d.pins.output_gate_n = 1'b1;
          d.st = eeprom_host_pkg::ST_FINISH;
        end
      end
      eeprom_host_pkg::ST_E_SETUP: begin
        if (t_expired) begin
          d.pins.write_strobe_n = 1'b0; // see [R17]
          t_load = 1'b1;
          t_value = eeprom_host_pkg::ld(ERASE_CYC);
          d.st = eeprom_host_pkg::ST_E_PULSE;
        end
      end
      eeprom_host_pkg::ST_E_PULSE: begin
        if (t_expired) begin
          d.pins.write_strobe_n = 1'b1;
          t_load = 1'b1;
          t_value = eeprom_host_pkg::ld(DH_CYC);
          d.st = eeprom_host_pkg::ST_E_HOLD;
        end
      end
      eeprom_host_pkg::ST_E_HOLD: begin
        if (t_expired) begin
          d.st = eeprom_host_pkg::ST_FINISH;
        end
      end
      eeprom_host_pkg::ST_FINISH: begin
        // Elevated qualifiers are dropped only once the access is over
        d.pins = PINS_IDLE;
        d.pins.word_address = q.pins.word_address;
        d.rsp_valid = 1'b1;
        d.req_ready = 1'b1;
        d.st = eeprom_host_pkg::ST_IDLE;
      end
      default: begin
        d = RST_Q;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      q <= RST_Q;
    end else if (clk_en) begin
      q <= d;
    end
  end

  assign req_ready = q.req_ready;
  assign rsp_valid = q.rsp_valid;
  assign rsp = q.rsp;
  assign pins = q.pins;

endmodule

`default_nettype wire

// file: hdl/eeprom_host_params.svh
// Constants for the host-side controller of a byte-wide parallel EEPROM.
// Assumes a 100 ns system clock; times are in ns and turned into cycles by the package.
//
// Overview of operation
// [R1] Memory has 8,192 bytes on 13 address lines and an 8-bit two-way data bus.
// [R2] Chip select low, output gate low, write strobe high reads the addressed byte.
// [R3] Device floats its data outputs whenever chip select or output gate is high.
// [R4] Write starts with a low strobe pulse, output gate high, chip select low.
// [R5] Device latches address on strobe fall and data on strobe rise.
// [R6] Device clears, then programs the byte, timed by its own internal timer.
// [R7] Byte write ends within 1 ms, or 200 us on the fast variant.
// [R8] During the write cycle every read acts as a completion poll.
// [R9] Open-drain done flag is low during the write cycle, released at its end.
// [R10] Without the ready line the host must poll to detect write completion.
// [R11] Poll read of the written location returns bit 7 inverted; others undefined.
// [R12] After the write cycle, reads return the true byte on all eight lanes.
// [R13] Host starts no new access until the current write cycle has ended.
// [R14] Device ignores writes while its supply is below about 3.8V.
// [R15] Device blocks writes for about 5 ms after supply reaches the threshold.
// [R16] No write while gate low, select high or strobe high; deselect means standby.
// [R17] Select low, gate elevated, 10 ms strobe pulse sets every bit high.
// [R18] Address line nine elevated maps 1FE0H-1FFFH to 32 identification bytes.
// [R19] Each elevated-voltage pin level is a separate digital qualifier signal.
// [R20] A cleared byte reads as all ones, 0xFF.
// [R21] Write cycle and power-on lockout durations are model parameters.
`ifndef EEPROM_HOST_PARAMS_SVH
`define EEPROM_HOST_PARAMS_SVH

`define CLK_PERIOD_NS 100
`define T_ADDR_SETUP_NS 10
`define T_WRITE_PULSE_NS 100
`define T_DATA_HOLD_NS 10
`define T_READ_ACCESS_NS 250
`define T_TO_BUSY_NS 50
`define T_POLL_GAP_NS 10
`define T_WRITE_CYCLE_NS 1000000
`define T_WRITE_CYCLE_FAST_NS 200000
`define T_LOCKOUT_NS 5000000
`define T_ERASE_PULSE_NS 10000000
`define ADDR_W 13
`define DATA_W 8
`define CNT_W 20
`define POLL_BIT 7
`define ID_OFS_W 5
`define ID_HIGH_BITS 8'hff
`define ERASED_BYTE 8'hff

`endif

// file: hdl/eeprom_host_pkg.sv
// Types and cycle arithmetic for the parallel EEPROM host controller.
// Assumes the constants header sits beside this file.
`include "eeprom_host_params.svh"

package eeprom_host_pkg;

  typedef enum logic [2:0] {
    CMD_READ = 3'h0,
    CMD_WRITE = 3'h1,
    CMD_ERASE = 3'h2,
    CMD_ID_READ = 3'h3,
    CMD_ID_WRITE = 3'h4
  } cmd_type;

  typedef enum logic [3:0] {
    ST_LOCKOUT = 4'h0,
    ST_IDLE = 4'h1,
    ST_W_SETUP = 4'h2,
    ST_W_PULSE = 4'h3,
    ST_W_HOLD = 4'h4,
    ST_W_SETTLE = 4'h5,
    ST_W_WAIT = 4'h6,
    ST_P_ACCESS = 4'h7,
    ST_P_GAP = 4'h8,
    ST_R_ACCESS = 4'h9,
    ST_E_SETUP = 4'ha,
    ST_E_PULSE = 4'hb,
    ST_E_HOLD = 4'hc,
    ST_FINISH = 4'hd
  } state_type;

  typedef struct packed {
    cmd_type cmd;
    logic [`ADDR_W-1:0] addr;
    logic [`DATA_W-1:0] data;
  } req_type;

  typedef struct packed {
    logic [`DATA_W-1:0] data;
    logic error;
  } rsp_type;

  typedef struct packed {
    logic [`ADDR_W-1:0] word_address;
    logic [`DATA_W-1:0] byte_lanes_out;
    logic byte_lanes_oe;
    logic chip_select_n;
    logic output_gate_n;
    logic write_strobe_n;
    logic output_gate_elevated;
    logic address_line_nine_elevated;
  } pins_type;

  // Least times round up, none below one cycle
  function automatic int unsigned cyc_up(input int unsigned ns);
    int unsigned c;
    c = (ns + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
    return (c == 0) ? 1 : c;
  endfunction

  // Longest times round down, none below one cycle
  function automatic int unsigned cyc_dn(input int unsigned ns);
    int unsigned c;
    c = ns / `CLK_PERIOD_NS;
    return (c == 0) ? 1 : c;
  endfunction

  // Timer load value so that a state lasts exactly n cycles
  function automatic logic [`CNT_W-1:0] ld(input int unsigned n);
    return `CNT_W'(n - 1);
  endfunction

endpackage

// file: hdl/interval_timer.sv
// Down-counter that marks the end of a timed interval.
// Assumes one clock domain; clk_en low freezes the count.
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_host_params.svh"

module interval_timer (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic load,
  input wire logic [`CNT_W-1:0] load_value,
  output logic expired
);

  typedef struct packed {
    logic [`CNT_W-1:0] cnt;
  } timer_state_type;

  timer_state_type q;
  timer_state_type d;

  always_comb begin
    d = q;
    if (load) begin
      d.cnt = load_value;
    end else if (q.cnt != '0) begin
      d.cnt = q.cnt - `CNT_W'(1);
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      q <= '0;
    end else if (clk_en) begin
      q <= d;
    end
  end

  assign expired = (q.cnt == '0);

endmodule

`default_nettype wire

// file: verif/eeprom_host_asserts.sv
// Property checker for the EEPROM host controller.
// Assumes it is bound to eeprom_host and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_host_params.svh"
module eeprom_host_asserts #(
  parameter int unsigned LOCKOUT_NS = 1000,
  parameter int unsigned ERASE_PULSE_NS = 1000
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic req_valid,
  input wire eeprom_host_pkg::req_type req,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire eeprom_host_pkg::rsp_type rsp,
  input wire eeprom_host_pkg::pins_type pins,
  input wire logic [`DATA_W-1:0] byte_lanes_in,
  input wire logic write_done_flag
);
  localparam int LOCK_CYC = (LOCKOUT_NS + 99) / 100;
  localparam int ERASE_CYC = (ERASE_PULSE_NS + 99) / 100;
  logic take;
  int low_q;
  int age_q;
  assign take = clk_en && req_valid && req_ready;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      low_q <= 0;
      age_q <= 0;
    end else begin
      low_q <= pins.write_strobe_n ? 0 : low_q + 1;
      age_q <= (age_q > LOCK_CYC) ? age_q : age_q + 1;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  rd_cycle_a: assert property (
    take && req.cmd == eeprom_host_pkg::CMD_READ |-> ##1
    (!pins.chip_select_n && !pins.output_gate_n && pins.write_strobe_n)[*3] ##2 rsp_valid)
    else $error("read strobes or answer out of step");
  wr_start_a: assert property (
    take && req.cmd == eeprom_host_pkg::CMD_WRITE |=> !pins.chip_select_n
    && pins.byte_lanes_oe && pins.byte_lanes_out == $past(req.data)
    && pins.word_address == $past(req.addr) ##1 !pins.write_strobe_n)
    else $error("write setup wrong");
  pulse_len_a: assert property (
    $rose(pins.write_strobe_n) |-> low_q == (pins.output_gate_elevated ? ERASE_CYC : 1))
    else $error("strobe pulse length wrong");
  data_hold_a: assert property (
    $rose(pins.write_strobe_n) && !pins.output_gate_elevated |-> pins.byte_lanes_oe
    && !pins.chip_select_n && $stable(pins.word_address) && $stable(pins.byte_lanes_out))
    else $error("data or address moved at strobe rise");
  wr_inhibit_a: assert property (
    !pins.write_strobe_n |-> !pins.chip_select_n
    && (pins.output_gate_n || pins.output_gate_elevated))
    else $error("strobe low outside a write");
  no_contend_a: assert property (pins.byte_lanes_oe |-> pins.output_gate_n)
    else $error("host drives lanes with gate low");
  busy_wait_a: assert property (
    !write_done_flag && $past(!write_done_flag) |-> pins.chip_select_n && !rsp_valid)
    else $error("access while device busy");
  lockout_a: assert property (req_ready |-> age_q >= LOCK_CYC)
    else $error("request taken during lockout");
  id_addr_a: assert property (
    pins.address_line_nine_elevated && !pins.chip_select_n |-> pins.word_address[12:5] == 8'hff)
    else $error("identification address out of range");
endmodule
bind eeprom_host eeprom_host_asserts #(.LOCKOUT_NS(LOCKOUT_NS),
  .ERASE_PULSE_NS(ERASE_PULSE_NS)) i_chk (.clk_sys(clk_sys), .nrst(nrst),
  .clk_en(clk_en), .req_valid(req_valid), .req(req), .req_ready(req_ready),
  .rsp_valid(rsp_valid), .rsp(rsp), .pins(pins), .byte_lanes_in(byte_lanes_in),
  .write_done_flag(write_done_flag));
`default_nettype wire

// file: verif/eeprom_dev_model.sv
// Behavioural byte-wide EEPROM facing the host pins.
// Assumes pins move on rising edges; it samples them on falling edges.
`timescale 1ns/1ps
`default_nettype none
module eeprom_dev_model #(
  parameter int BUSY_CYC = 12,
  parameter int LOCK_CYC = 10
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire eeprom_host_pkg::pins_type pins,
  output logic [7:0] lanes,
  output logic rdy
);
  logic [7:0] mem [0:8191];
  logic [7:0] idm [0:31];
  logic [7:0] wd;
  logic [7:0] last;
  logic [7:0] q;
  logic [12:0] wa;
  logic wid;
  logic we_q;
  logic busy;
  logic rd;
  logic idsel;
  int cnt;
  int lk;
  assign idsel = pins.address_line_nine_elevated && pins.word_address[12:5] == 8'hff;
  assign rd = !pins.chip_select_n && !pins.output_gate_n && pins.write_strobe_n;
  // While busy every read is a poll; only bit 7 carries meaning
  assign q = busy ? {~wd[7], ~last[6:0]} :
    idsel ? idm[pins.word_address[4:0]] : mem[pins.word_address];
  // Undriven lanes flip each cycle so a stale byte never passes
  assign lanes = pins.byte_lanes_oe ? pins.byte_lanes_out : rd ? q : ~last;
  assign rdy = !busy;
  always @(negedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      we_q <= 1'b1;
      busy <= 1'b0;
      lk <= LOCK_CYC;
      last <= 8'h00;
    end else begin
      last <= lanes;
      we_q <= pins.write_strobe_n;
      if (lk != 0) lk <= lk - 1;
      if (we_q && !pins.write_strobe_n) begin
        wa <= pins.word_address;
        wid <= idsel;
      end
      if (!we_q && pins.write_strobe_n && !pins.chip_select_n && lk == 0 && !busy) begin
        if (pins.output_gate_elevated) begin
          for (int i = 0; i < 8192; i++) mem[i] <= 8'hff;
        end else if (pins.output_gate_n) begin
          wd <= lanes;
          busy <= 1'b1;
          cnt <= BUSY_CYC;
          if (wid) idm[wa[4:0]] <= 8'hff;
          else mem[wa] <= 8'hff;
        end
      end
      if (busy) begin
        cnt <= cnt - 1;
        if (cnt == 1) begin
          busy <= 1'b0;
          if (wid) idm[wa[4:0]] <= wd;
          else mem[wa] <= wd;
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: verif/tb_top.sv
// Self-checking bench: host controller driving the device model.
// Assumes design, checker and model files are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic req_valid = 1'b0;
  logic clk_en = 1'b1;
  eeprom_host_pkg::req_type req = '0;
  eeprom_host_pkg::rsp_type rsp;
  eeprom_host_pkg::rsp_type r;
  eeprom_host_pkg::pins_type pins;
  logic req_ready;
  logic rsp_valid;
  logic rdy;
  logic [7:0] lanes;
  int fail_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  int n;
  always #50 clk_sys = ~clk_sys;
  // Short times keep the run small; the model stays busy 12 cycles
  eeprom_host #(.WRITE_CYCLE_NS(2000), .LOCKOUT_NS(1000), .ERASE_PULSE_NS(1000),
    .USE_READY_LINE(1'b1)) i_eeprom_host (.clk_sys(clk_sys), .nrst(nrst),
    .clk_en(clk_en), .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp(rsp), .pins(pins), .byte_lanes_in(lanes),
    .write_done_flag(rdy));
  eeprom_dev_model i_eeprom_dev_model (
    .clk_sys(clk_sys), .nrst(nrst), .pins(pins), .lanes(lanes), .rdy(rdy));
  task automatic check(input logic [8:0] got, input logic [8:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    if (fail_count == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Holds the request until taken; n ends as the answer latency
  task automatic op(input logic [2:0] c, input logic [12:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    req_valid = 1'b1;
    req = {c, a, d};
    while (req_ready !== 1'b1) @(negedge clk_sys);
    @(negedge clk_sys);
    req_valid = 1'b0;
    n = 1;
    while (rsp_valid !== 1'b1) begin
      @(negedge clk_sys);
      n++;
    end
    r = rsp;
  endtask
  task automatic t_lockout;
    n = 0;
    while (req_ready !== 1'b1) begin
      check(9'({pins.chip_select_n, pins.output_gate_n, pins.write_strobe_n,
        pins.byte_lanes_oe}), 9'h00e);
      @(negedge clk_sys);
      n++;
    end
    check(9'(n >= 10), 9'h001);
  endtask
  task automatic t_rw;
    logic [12:0] a [3] = '{13'h0000, 13'h1fff, 13'h0aa5};
    logic [7:0] d [3] = '{8'h5a, 8'h00, 8'h81};
    for (int i = 0; i < 3; i++) begin
      op(3'h1, a[i], d[i]);
      check(9'(r.error), 9'h000);
      check(9'(n >= 12), 9'h001);
      op(3'h0, a[i], 8'h00);
      check(r, {d[i], 1'b0});
    end
    // Overwrite that sets bits the old byte had clear: only a clear first gives the new byte
    op(3'h1, 13'h0000, 8'h3c);
    op(3'h0, 13'h0000, 8'h00);
    check(r, {8'h3c, 1'b0});
  endtask
  // Enable low must hold off the take; the request waits unserved
  task automatic t_freeze;
    @(negedge clk_sys);
    clk_en = 1'b0;
    req_valid = 1'b1;
    req = {3'h0, 13'h0000, 8'h00};
    repeat (4) @(negedge clk_sys);
    check(9'({req_ready, pins.chip_select_n}), 9'h003);
    clk_en = 1'b1;
    @(negedge clk_sys);
    req_valid = 1'b0;
    while (rsp_valid !== 1'b1) @(negedge clk_sys);
    check(rsp, {8'h3c, 1'b0});
  endtask
  task automatic t_erase;
    op(3'h2, 13'h0000, 8'h00);
    check(9'(r.error), 9'h000);
    op(3'h0, 13'h1fff, 8'h00);
    check(r, {8'hff, 1'b0});
  endtask
  task automatic t_id;
    op(3'h4, 13'h001f, 8'hc3);
    op(3'h3, 13'h001f, 8'h00);
    check(r, {8'hc3, 1'b0});
    op(3'h0, 13'h1fff, 8'h00);
    check(r, {8'hff, 1'b0});
  endtask
  task automatic t_bad;
    op(3'h7, 13'h0000, 8'h00);
    check(9'(r.error), 9'h001);
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      summarize();
    end
  end
  initial begin
    repeat (10) @(negedge clk_sys);
    nrst = 1'b1;
    t_lockout();
    t_rw();
    t_freeze();
    t_erase();
    t_id();
    t_bad();
    summarize();
  end
endmodule
`default_nettype wire
